// ==== rtl/icr_ctrl2.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - A one in the vector-table select bit makes vectors come from the alternate table, zero the standard one.
// - Bit 14 reads one while a disable-interrupts instruction is active, and writes to it do nothing.
// - Bits 13 to 3 read as zero and ignore writes.
// - Bits 2, 1 and 0 select the edge polarity of external inputs two, one and zero.
// - Polarity one fires on a falling edge, polarity zero on a rising edge.
// - All implemented bits are zero after reset.
module icr_ctrl2
  import icr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core status and external pins
  input wire logic irq_disable_instr_active,
  input wire logic [ICR_NUM_EXT-1:0] ext_irq_pin,
  // Outputs to the interrupt logic
  output logic alt_vector_table_select,
  output logic [ICR_NUM_EXT-1:0] ext_irq_flag
);
  typedef enum {ICR_W_IDLE, ICR_W_RESP} icr_wstate_t;
  typedef enum {ICR_R_IDLE, ICR_R_RESP} icr_rstate_t;

  typedef struct packed {
    icr_wstate_t wst;
    icr_rstate_t rst;
    logic aw_have;
    logic w_have;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic altvt;
    logic dis_instr;
    logic [ICR_NUM_EXT-1:0] pol;
    logic [ICR_NUM_EXT-1:0] prev;
    logic [ICR_NUM_EXT-1:0] flag;
  } icr_state_t;

  icr_state_t s_q, s_d;
  logic [ICR_NUM_EXT-1:0] pin_sync;
  logic [15:0] ctrl2_view;
  logic [15:0] wmerged;

  // One word per register, so only address bits 3:2 select; bits 1:0 are ignored
  function automatic logic icr_hit(input logic [3:0] addr, input logic [3:0] reg_addr);
    icr_hit = (addr[3:2] == reg_addr[3:2]);
  endfunction

  // ==========================================================
  // Input synchronisation
  icr_sync icr_sync_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(ext_irq_pin),
    .sync_out(pin_sync)
  );

  // Unimplemented bits are built as constant zero
  always_comb begin
    ctrl2_view = '0;
    ctrl2_view[ICR_BIT_ALTVT] = s_q.altvt;
    ctrl2_view[ICR_BIT_DIS_INSTR] = s_q.dis_instr;
    ctrl2_view[ICR_BIT_EP2:ICR_BIT_EP0] = s_q.pol;
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    wmerged = ctrl2_view;
    s_d.dis_instr = irq_disable_instr_active;
    // Edges compare synchronised levels only, so changing polarity on a steady pin raises nothing
    for (int i = 0; i < ICR_NUM_EXT; i++) begin
      s_d.flag[i] = icr_edge(s_q.prev[i], pin_sync[i], s_q.pol[i]);
    end
    s_d.prev = pin_sync;

    // Write channel: address and data taken independently, response after both
    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr;
      s_d.awready = 1'b0;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
      s_d.wready = 1'b0;
    end
    case (s_q.wst)
      ICR_W_IDLE: begin
        if (s_q.aw_have && s_q.w_have) begin
          s_d.bvalid = 1'b1;
          s_d.wst = ICR_W_RESP;
          s_d.aw_have = 1'b0;
          s_d.w_have = 1'b0;
          if (icr_hit(s_q.awaddr, ICR_ADDR_CTRL2)) begin
            if (s_q.wstrb[0]) wmerged[7:0] = s_q.wdata[7:0];
            if (s_q.wstrb[1]) wmerged[15:8] = s_q.wdata[15:8];
            wmerged = wmerged & ICR_CTRL2_WMASK;
            s_d.altvt = wmerged[ICR_BIT_ALTVT];
            s_d.pol = wmerged[ICR_BIT_EP2:ICR_BIT_EP0];
            s_d.bresp = ICR_RESP_OKAY;
          end else if (icr_hit(s_q.awaddr, ICR_ADDR_STATUS)) begin
            s_d.bresp = ICR_RESP_OKAY; // Read-only, write ignored
          end else begin
            s_d.bresp = ICR_RESP_SLVERR;
          end
        end
      end
      ICR_W_RESP: begin
        if (s_axi_bready) begin
          s_d.bvalid = 1'b0;
          s_d.awready = 1'b1;
          s_d.wready = 1'b1;
          s_d.wst = ICR_W_IDLE;
        end
      end
      default: s_d.wst = ICR_W_IDLE;
    endcase

    // Read channel
    case (s_q.rst)
      ICR_R_IDLE: begin
        if (s_q.arready && s_axi_arvalid) begin
          s_d.arready = 1'b0;
          s_d.rvalid = 1'b1;
          s_d.rst = ICR_R_RESP;
          s_d.rresp = ICR_RESP_OKAY;
          if (icr_hit(s_axi_araddr, ICR_ADDR_CTRL2)) begin
            s_d.rdata = {16'h0000, ctrl2_view};
          end else if (icr_hit(s_axi_araddr, ICR_ADDR_STATUS)) begin
            s_d.rdata = {29'h0000000, s_q.flag};
          end else begin
            s_d.rdata = 32'h00000000;
            s_d.rresp = ICR_RESP_SLVERR;
          end
        end
      end
      ICR_R_RESP: begin
        if (s_axi_rready) begin
          s_d.rvalid = 1'b0;
          s_d.arready = 1'b1;
          s_d.rst = ICR_R_IDLE;
        end
      end
      default: s_d.rst = ICR_R_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.wst <= ICR_W_IDLE;
      s_q.rst <= ICR_R_IDLE;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.altvt <= ICR_CTRL2_RESET[ICR_BIT_ALTVT];
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;
  assign alt_vector_table_select = s_q.altvt;
  assign ext_irq_flag = s_q.flag;

  // ==========================================================
  // Assertions
  sequence seq_wr_ctrl2;
    s_q.wst == ICR_W_IDLE && s_q.aw_have && s_q.w_have && s_q.awaddr[3:2] == ICR_ADDR_CTRL2[3:2] && s_q.wstrb[1];
  endsequence

  a_altvt_write: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_wr_ctrl2 |=> alt_vector_table_select == $past(s_q.wdata[ICR_BIT_ALTVT]))
    else $error("vector select did not take written value");

  a_dis_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 s_q.dis_instr == $past(irq_disable_instr_active))
    else $error("disable status does not follow core");

  a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && s_q.rresp == ICR_RESP_OKAY) |-> s_axi_rdata[13:3] == 11'h000)
    else $error("unimplemented bits read nonzero");

  a_pol_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.wst == ICR_W_IDLE && s_q.aw_have && s_q.w_have && s_q.awaddr[3:2] == ICR_ADDR_CTRL2[3:2] && s_q.wstrb[0])
    |=> s_q.pol == $past(s_q.wdata[2:0]))
    else $error("polarity bits did not take written value");

  a_rise_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (!s_q.pol[0] && !s_q.prev[0] && pin_sync[0]) |=> ext_irq_flag[0])
    else $error("rising edge missed");

  a_fall_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.pol[1] && s_q.prev[1] && !pin_sync[1]) |=> ext_irq_flag[1])
    else $error("falling edge missed");

  a_reset_zero: assert property (@(posedge aclk)
    !aresetn |=> (alt_vector_table_select == 1'b0 && s_q.pol == 3'h0 && ext_irq_flag == 3'h0))
    else $error("implemented bits not zero after reset");

  a_flag_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    (ext_irq_flag[2] && $stable(s_q.pol)) |=> !ext_irq_flag[2])
    else $error("flag held for more than one cycle");

  a_bresp_after: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.wst == ICR_W_IDLE && s_q.aw_have && s_q.w_have) |=> s_axi_bvalid)
    else $error("write response late");

  a_resp_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write channel open while response pending");

  a_rd_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read data late");

  a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half of read data nonzero");

  a_slverr_data: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && s_axi_rresp == ICR_RESP_SLVERR) |-> s_axi_rdata == 32'h00000000)
    else $error("refused read returned data");

  a_reset_idle: assert property (@(posedge aclk)
    !aresetn |=> (s_axi_awready && s_axi_wready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid))
    else $error("bus not idle after reset");

  a_status_reset: assert property (@(posedge aclk)
    !aresetn |=> !s_q.dis_instr)
    else $error("disable status not zero after reset");

  // A write to the flag word must leave the control fields alone
  sequence seq_wr_status;
    s_q.wst == ICR_W_IDLE && s_q.aw_have && s_q.w_have && icr_hit(s_q.awaddr, ICR_ADDR_STATUS);
  endsequence

  a_status_ro: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_wr_status |=> ($stable(s_q.altvt) && $stable(s_q.pol)))
    else $error("write to flag word changed control fields");

  a_dis_ro: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_wr_ctrl2 |=> s_q.dis_instr == $past(irq_disable_instr_active))
    else $error("write reached the disable status bit");

  a_alt_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.wst == ICR_W_IDLE && s_q.aw_have && s_q.w_have && icr_hit(s_q.awaddr, ICR_ADDR_CTRL2) && !s_q.wstrb[1])
    |=> $stable(alt_vector_table_select))
    else $error("vector select changed without its byte strobe");

  a_pol_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.wst == ICR_W_IDLE && s_q.aw_have && s_q.w_have && icr_hit(s_q.awaddr, ICR_ADDR_CTRL2) && !s_q.wstrb[0])
    |=> $stable(s_q.pol))
    else $error("polarity changed without its byte strobe");

  a_no_false_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (pin_sync == s_q.prev) |=> ext_irq_flag == 3'h0)
    else $error("flag raised without an edge");

  a_wrong_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.pol[0] && !s_q.prev[0] && pin_sync[0]) |=> !ext_irq_flag[0])
    else $error("rising edge fired on falling polarity");

  a_rise_flag2: assert property (@(posedge aclk) disable iff (!aresetn)
    (!s_q.pol[2] && !s_q.prev[2] && pin_sync[2]) |=> ext_irq_flag[2])
    else $error("rising edge missed on input two");

  a_fall_flag0: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.pol[0] && s_q.prev[0] && !pin_sync[0]) |=> ext_irq_flag[0])
    else $error("falling edge missed on input zero");

  a_flag_pulse0: assert property (@(posedge aclk) disable iff (!aresetn)
    (ext_irq_flag[0] && $stable(s_q.pol)) |=> !ext_irq_flag[0])
    else $error("flag zero held for more than one cycle");
endmodule // icr_ctrl2

// ==== common/icr_pkg.sv ====
package icr_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] ICR_ADDR_CTRL2 = 4'h0;
  localparam logic [3:0] ICR_ADDR_STATUS = 4'h4;
  // ==========================================================
  // Field positions
  localparam int ICR_BIT_ALTVT = 15;
  localparam int ICR_BIT_DIS_INSTR = 14;
  localparam int ICR_BIT_EP2 = 2;
  localparam int ICR_BIT_EP1 = 1;
  localparam int ICR_BIT_EP0 = 0;
  localparam int ICR_NUM_EXT = 3;
  // ==========================================================
  // Reset value, write mask and response codes
  localparam logic [15:0] ICR_CTRL2_RESET = 16'h0000;
  localparam logic [15:0] ICR_CTRL2_WMASK = 16'h8007;
  localparam logic [1:0] ICR_RESP_OKAY = 2'h0;
  localparam logic [1:0] ICR_RESP_SLVERR = 2'h2;

  // Rising edge when polarity is 0, falling edge when 1
  function automatic logic icr_edge(input logic prev, input logic cur, input logic pol);
    icr_edge = pol ? (prev & ~cur) : (~prev & cur);
  endfunction
endpackage

// ==== rtl/icr_sync.sv ====
`timescale 1ns/10ps
// Two-flop synchroniser for the external request pins
module icr_sync
  import icr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [ICR_NUM_EXT-1:0] async_in,
  output logic [ICR_NUM_EXT-1:0] sync_out
);
  typedef struct packed {
    logic [ICR_NUM_EXT-1:0] meta;
    logic [ICR_NUM_EXT-1:0] sync;
  } icr_sync_state_t;

  icr_sync_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.sync;
endmodule // icr_sync

// ==== testbench/icr_pin_model.sv ====
`timescale 1ns/10ps
// ==========================================
// External request pins
module icr_pin_model
  import icr_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Control from the bench
  input wire logic slow,
  input wire logic [ICR_NUM_EXT-1:0] target,
  // Pins
  output logic [ICR_NUM_EXT-1:0] pin
);
  int lag_n = 0;
  initial pin = '0;
  // Slow mode holds each change back a few cycles, like a weak external driver
  always @(posedge aclk) begin
    if (pin !== target) begin
      if (lag_n >= (slow ? 4 : 0)) begin
        pin <= target;
        lag_n = 0;
      end else begin
        lag_n++;
      end
    end
  end
endmodule // icr_pin_model

// ==== testbench/interrupt_control_reg2_tb.sv ====
`timescale 1ns/10ps
module interrupt_control_reg2_tb;
  import icr_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic dis_instr, slow, alt;
  logic [2:0] pins, target, flag;
  int err_count = 0;
  int checks_done = 0;
  int cnt [3] = '{0, 0, 0};
  // ==========================================
  // Clock, instances, flag counting
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  icr_ctrl2 icr_ctrl2_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_disable_instr_active(dis_instr),
    .ext_irq_pin(pins), .alt_vector_table_select(alt), .ext_irq_flag(flag));
  icr_pin_model icr_pin_model_inst (.aclk(aclk), .slow(slow), .target(target), .pin(pins));
  // Counting every high cycle catches a flag that stays up too long
  always @(posedge aclk) for (int i = 0; i < 3; i++) cnt[i] += flag[i];
  // ==========================================
  // Bus and check tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits end only on the answer; a hang is left to the watchdog
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(what, d, exp);
    chk("read response", r, er);
  endtask
  // ==========================================
  // Scenarios
  task automatic test_fields;
    logic [1:0] r;
    rd_chk("ctrl after reset", ICR_ADDR_CTRL2, 32'h0, ICR_RESP_OKAY);
    chk("alt after reset", alt, 1'b0);
    axi_wr(ICR_ADDR_CTRL2, 32'hffff_ffff, r);
    chk("write response", r, ICR_RESP_OKAY);
    rd_chk("ctrl all ones", ICR_ADDR_CTRL2, 32'h0000_8007, ICR_RESP_OKAY);
    chk("alt set", alt, 1'b1);
    axi_wr(ICR_ADDR_CTRL2, 32'h0000_7ff8, r);
    rd_chk("ctrl clear", ICR_ADDR_CTRL2, 32'h0, ICR_RESP_OKAY);
    chk("alt clear", alt, 1'b0);
    wstrb <= 4'h2;
    axi_wr(ICR_ADDR_CTRL2, 32'hffff_ffff, r);
    rd_chk("ctrl high byte", ICR_ADDR_CTRL2, 32'h0000_8000, ICR_RESP_OKAY);
    wstrb <= 4'h1;
    axi_wr(ICR_ADDR_CTRL2, 32'hffff_ffff, r);
    rd_chk("ctrl low byte", ICR_ADDR_CTRL2, 32'h0000_8007, ICR_RESP_OKAY);
    wstrb <= 4'hf;
    $display("field test done");
  endtask
  task automatic test_dis_instr;
    logic [1:0] r;
    dis_instr <= 1'b1;
    axi_wr(ICR_ADDR_CTRL2, 32'h0, r);
    rd_chk("status on", ICR_ADDR_CTRL2, 32'h0000_4000, ICR_RESP_OKAY);
    dis_instr <= 1'b0;
    rd_chk("status off", ICR_ADDR_CTRL2, 32'h0, ICR_RESP_OKAY);
    $display("status test done");
  endtask
  task automatic test_refuse;
    logic [1:0] r;
    axi_wr(4'h8, 32'hffff_ffff, r);
    chk("unmapped write", r, ICR_RESP_SLVERR);
    rd_chk("unmapped read", 4'h8, 32'h0, ICR_RESP_SLVERR);
    axi_wr(ICR_ADDR_STATUS, 32'hffff_ffff, r);
    chk("status write", r, ICR_RESP_OKAY);
    rd_chk("ctrl untouched", ICR_ADDR_CTRL2, 32'h0000_0002, ICR_RESP_OKAY);
    rd_chk("flags idle", ICR_ADDR_STATUS, 32'h0, ICR_RESP_OKAY);
    $display("refusal test done");
  endtask
  // A second reset in mid-run must clear fields that software has set
  task automatic test_reset;
    logic [1:0] r;
    axi_wr(ICR_ADDR_CTRL2, 32'hffff_ffff, r);
    chk("alt before reset", alt, 1'b1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk("alt in reset", alt, 1'b0);
    rd_chk("ctrl after second reset", ICR_ADDR_CTRL2, 32'h0, ICR_RESP_OKAY);
    $display("reset test done");
  endtask
  task automatic edge_test(input logic [2:0] pol, input logic s);
    logic [1:0] r;
    int b [3];
    slow <= s;
    axi_wr(ICR_ADDR_CTRL2, {29'h0, pol}, r);
    repeat (12) @(posedge aclk);
    b = cnt;
    target <= 3'b111;
    repeat (16) @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      chk("rise flags", cnt[i] - b[i], !pol[i]);
    end
    target <= 3'b000;
    repeat (16) @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      chk("total flags", cnt[i] - b[i], 32'h1);
    end
    $display("edge test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, dis_instr, slow} = '0;
    {awaddr, araddr, wdata, target} = '0;
    wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    test_fields;
    test_dis_instr;
    edge_test(3'b101, 1'b0);
    edge_test(3'b010, 1'b1);
    test_refuse;
    test_reset;
    report_and_stop;
  end
  initial begin
    repeat (3000) @(posedge aclk);
    err_count++;
    report_and_stop;
  end
endmodule // interrupt_control_reg2_tb
